//--- rtl/low_voltage_detect_control.sv
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
// Operation
// - action select picks interrupt or reset
// - enabled reset mode locks control and level writes
// - reset held while supply below level
// - disable stops interrupts and resets
// - retention drop sets RAM invalid flag
// - watchdog or pin reset during access sets
// - emulation register active only in emulation
// - force bit write sets RAM invalid
// - force held blocks software clear
// - control resets zero, bits 7,1,0
// - flag shows synchronised comparator when enabled
// - flag drives interrupt in interrupt mode
// - RAM flag resets one, protected clear
module low_voltage_detect_control
   import lvd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic lockRelease,
   input wire logic cmpBelowLevel,
   input wire logic cmpBelowRetention,
   input wire logic watchdogRamReset,
   input wire logic emulationMode,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   output logic low_volt_irq,
   output logic low_volt_reset,
   output logic [0:0] detect_level_select
);
   // ----------------------------------------
   // Comparator synchronisation
   // ----------------------------------------
   logic [1:0] cmpSync;
   logic belowLevel;
   logic belowRetention;

   lvd_sync #(.WIDTH(2)) uSync (
      .ref_clk(ref_clk),
      .rst(rst),
      .asyncIn({cmpBelowRetention, cmpBelowLevel}),
      .syncOut(cmpSync)
   );
   assign belowLevel = cmpSync[0];
   assign belowRetention = cmpSync[1];

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   lvd_bus_t bus;
   lvd_ctrl_t ctrl_r;
   lvd_ctrl_t ctrl_nxt;
   lvd_prot_t prot_r;
   lvd_prot_t prot_nxt;
   logic level_r;
   logic level_nxt;
   logic ramInvalid_r;
   logic ramInvalid_nxt;
   logic force_r;
   logic force_nxt;
   logic locked;
   logic protOk;
   logic wrCtrl;
   logic wrLevel;
   logic wrRams;
   logic wrEmu;
   logic wrKey;
   logic forceActive;
   logic lowVoltFlag;
   logic ramSet;
   logic ramClr;
   logic ctrlWrOk;
   logic levelWrOk;
   logic [7:0] rdMux;

   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
   assign wrCtrl = bus.wr && (bus.addr == LVD_ADDR_CTRL);
   assign wrLevel = bus.wr && (bus.addr == LVD_ADDR_LEVEL);
   assign wrRams = bus.wr && (bus.addr == LVD_ADDR_RAMSTATE);
   assign wrEmu = bus.wr && (bus.addr == LVD_ADDR_EMU);
   assign wrKey = bus.wr && (bus.addr == LVD_ADDR_PROTECT) && (bus.wdata == LVD_PROTECT_KEY);
   // Protected write: key write arms exactly the next write
   assign protOk = (prot_r == LVD_PROT_ARMED);

   // Lock holds until rst or a reset from another source; lockRelease stands for that
   assign locked = ctrl_r.detectEnable && ctrl_r.actionSelect;
   // Writes that survive the lock, and for control also the key check
   assign ctrlWrOk = wrCtrl && protOk && !locked;
   assign levelWrOk = wrLevel && !locked;

   // ----------------------------------------
   // Detection and action
   // ----------------------------------------
   assign lowVoltFlag = ctrl_r.detectEnable && belowLevel;
   assign low_volt_irq = lowVoltFlag && !ctrl_r.actionSelect;
   assign low_volt_reset = lowVoltFlag && ctrl_r.actionSelect;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Any write other than the key disarms; reads leave the key armed
   always_comb begin
      prot_nxt = prot_r;
      case (prot_r)
         LVD_PROT_IDLE: begin
            if (wrKey) begin
               prot_nxt = LVD_PROT_ARMED;
            end
         end
         LVD_PROT_ARMED: begin
            if (bus.wr && !wrKey) begin
               prot_nxt = LVD_PROT_IDLE;
            end
         end
         default: prot_nxt = LVD_PROT_IDLE;
      endcase
   end

   always_comb begin
      ctrl_nxt = ctrl_r;
      level_nxt = level_r;
      if (ctrlWrOk) begin
         ctrl_nxt.detectEnable = bus.wdata[LVD_BIT_ENABLE];
         ctrl_nxt.actionSelect = bus.wdata[LVD_BIT_ACTION];
      end
      if (levelWrOk) begin
         level_nxt = bus.wdata[LVD_BIT_LEVEL];
      end
   end

   // Emulation register ignored outside emulation mode
   assign forceActive = emulationMode && force_r;
   assign force_nxt = !emulationMode ? 1'b0 : (wrEmu ? bus.wdata[LVD_BIT_FORCE] : force_r);
   assign ramSet = belowRetention || watchdogRamReset || forceActive;
   // Set beats clear; force also blocks clearing
   assign ramClr = wrRams && protOk && !bus.wdata[LVD_BIT_RAM_INVALID_FLAG] && !forceActive;
   assign ramInvalid_nxt = ramSet ? 1'b1 : (ramClr ? 1'b0 : ramInvalid_r);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Control, level and key state also clear on a reset from another source
   always_ff @(posedge ref_clk) begin
      if (rst || lockRelease) begin
         ctrl_r <= '{detectEnable: LVD_CTRL_RST[LVD_BIT_ENABLE],
                     actionSelect: LVD_CTRL_RST[LVD_BIT_ACTION]};
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || lockRelease) begin
         level_r <= LVD_LEVEL_RST[LVD_BIT_LEVEL];
      end else begin
         level_r <= level_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || lockRelease) begin
         prot_r <= LVD_PROT_IDLE;
      end else begin
         prot_r <= prot_nxt;
      end
   end

   // The RAM flag survives a lock release: only a full reset reloads it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ramInvalid_r <= LVD_RAM_STATE_REG_RST[LVD_BIT_RAM_INVALID_FLAG];
      end else begin
         ramInvalid_r <= ramInvalid_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         force_r <= LVD_EMU_RST[LVD_BIT_FORCE];
      end else begin
         force_r <= force_nxt;
      end
   end

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always_comb begin
      rdMux = 8'h00;
      case (bus.addr)
         LVD_ADDR_CTRL: begin
            rdMux[LVD_BIT_ENABLE] = ctrl_r.detectEnable;
            rdMux[LVD_BIT_ACTION] = ctrl_r.actionSelect;
            rdMux[LVD_BIT_FLAG] = lowVoltFlag;
         end
         LVD_ADDR_LEVEL: rdMux[LVD_BIT_LEVEL] = level_r;
         LVD_ADDR_RAMSTATE: rdMux[LVD_BIT_RAM_INVALID_FLAG] = ramInvalid_r;
         LVD_ADDR_EMU: rdMux[LVD_BIT_FORCE] = force_r;
         default: rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else begin
         rdata <= bus.rd ? rdMux : 8'h00;
      end
   end

   assign detect_level_select = level_r;
endmodule : low_voltage_detect_control

//--- rtl/lvd_pkg.sv
package lvd_pkg;
   // ----------------------------------------
   // Register map (byte offsets on the plain port)
   // ----------------------------------------
   localparam logic [3:0] LVD_ADDR_CTRL = 4'h0;
   localparam logic [3:0] LVD_ADDR_LEVEL = 4'h1;
   localparam logic [3:0] LVD_ADDR_RAMSTATE = 4'h2;
   localparam logic [3:0] LVD_ADDR_EMU = 4'h3;
   localparam logic [3:0] LVD_ADDR_PROTECT = 4'h4;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int LVD_BIT_ENABLE = 7;
   localparam int LVD_BIT_ACTION = 1;
   localparam int LVD_BIT_FLAG = 0;
   localparam int LVD_BIT_LEVEL = 0;
   localparam int LVD_BIT_RAM_INVALID_FLAG = 0;
   localparam int LVD_BIT_FORCE = 0;
   localparam logic [7:0] LVD_CTRL_RST = 8'h00;
   localparam logic [7:0] LVD_RAM_STATE_REG_RST = 8'h01;
   localparam logic [7:0] LVD_LEVEL_RST = 8'h00;
   localparam logic [7:0] LVD_EMU_RST = 8'h00;
   localparam logic [7:0] LVD_PROTECT_KEY = 8'ha5;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } lvd_bus_t;

   typedef struct packed {
      logic detectEnable;
      logic actionSelect;
   } lvd_ctrl_t;

   typedef enum logic [0:0] {
      LVD_PROT_IDLE = 1'b0,
      LVD_PROT_ARMED = 1'b1
   } lvd_prot_t;
endpackage : lvd_pkg

//--- rtl/lvd_sync.sv
`timescale 1ns/1ns
module lvd_sync #(
   parameter int WIDTH = 2
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;

   if (WIDTH < 1) begin : g_width_check
      $error("lvd_sync: WIDTH must be positive");
   end

   // First stage feeds only the second
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stage1_r <= '0;
         stage2_r <= '0;
      end else begin
         stage1_r <= asyncIn;
         stage2_r <= stage1_r;
      end
   end

   assign syncOut = stage2_r;
endmodule : lvd_sync

//--- testbench/low_voltage_detect_control_bench.sv
`timescale 1ns/1ns
module low_voltage_detect_control_bench import lvd_pkg::*; ;
   logic ref_clk = 0, rst = 1, lockRelease = 0, cmpBelowLevel = 0, cmpBelowRetention = 0;
   logic watchdogRamReset = 0, emulationMode = 0, wr = 0, rd = 0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata;
   logic low_volt_irq, low_volt_reset;
   logic [0:0] detect_level_select;
   int fails = 0, n_compared = 0;
   always #10 ref_clk = ~ref_clk;
   low_voltage_detect_control uut (.ref_clk(ref_clk), .rst(rst), .lockRelease(lockRelease),
      .cmpBelowLevel(cmpBelowLevel), .cmpBelowRetention(cmpBelowRetention),
      .watchdogRamReset(watchdogRamReset), .emulationMode(emulationMode), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .low_volt_irq(low_volt_irq),
      .low_volt_reset(low_volt_reset), .detect_level_select(detect_level_select));
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge ref_clk) wr <= 1'b0;
   endtask : wreg
   task kwr(input logic [3:0] a, input logic [7:0] d);
      wreg(LVD_ADDR_PROTECT, LVD_PROTECT_KEY);
      wreg(a, d);
   endtask : kwr
   task rchk(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk) begin addr <= a; rd <= 1'b1; end
      @(posedge ref_clk) rd <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask : rchk
   task setcmp(input logic v);
      @(posedge ref_clk) cmpBelowLevel <= v;
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : setcmp
   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test
   initial begin
      #200000 fails++;
      end_of_test();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      rchk(LVD_ADDR_CTRL, LVD_CTRL_RST);
      rchk(LVD_ADDR_RAMSTATE, LVD_RAM_STATE_REG_RST);
      rchk(4'hf, 8'h00);
      wreg(LVD_ADDR_CTRL, 8'h80);
      rchk(LVD_ADDR_CTRL, 8'h00);
      wreg(LVD_ADDR_LEVEL, 8'h01);
      rchk(LVD_ADDR_LEVEL, 8'h01);
      chk("level", 8'h01, 8'(detect_level_select));
      kwr(LVD_ADDR_CTRL, 8'h80);
      rchk(LVD_ADDR_CTRL, 8'h80);
      setcmp(1'b1);
      chk("irq", 8'h01, 8'(low_volt_irq));
      chk("reset", 8'h00, 8'(low_volt_reset));
      rchk(LVD_ADDR_CTRL, 8'h81);
      kwr(LVD_ADDR_CTRL, 8'h00);
      rchk(LVD_ADDR_CTRL, 8'h00);
      chk("irq", 8'h00, 8'(low_volt_irq));
      setcmp(1'b0);
      kwr(LVD_ADDR_CTRL, 8'h80);
      rchk(LVD_ADDR_CTRL, 8'h80);
      kwr(LVD_ADDR_CTRL, 8'h82);
      setcmp(1'b1);
      chk("reset", 8'h01, 8'(low_volt_reset));
      chk("irq", 8'h00, 8'(low_volt_irq));
      kwr(LVD_ADDR_CTRL, 8'h00);
      wreg(LVD_ADDR_LEVEL, 8'h00);
      rchk(LVD_ADDR_CTRL, 8'h83);
      rchk(LVD_ADDR_LEVEL, 8'h01);
      setcmp(1'b0);
      chk("reset", 8'h00, 8'(low_volt_reset));
      @(posedge ref_clk) lockRelease <= 1'b1;
      @(posedge ref_clk) lockRelease <= 1'b0;
      rchk(LVD_ADDR_CTRL, 8'h00);
      rchk(LVD_ADDR_LEVEL, 8'h00);
      kwr(LVD_ADDR_RAMSTATE, 8'h00);
      rchk(LVD_ADDR_RAMSTATE, 8'h00);
      @(posedge ref_clk) cmpBelowRetention <= 1'b1;
      repeat (3) @(posedge ref_clk);
      cmpBelowRetention <= 1'b0;
      rchk(LVD_ADDR_RAMSTATE, 8'h01);
      wreg(LVD_ADDR_RAMSTATE, 8'h00);
      rchk(LVD_ADDR_RAMSTATE, 8'h01);
      kwr(LVD_ADDR_RAMSTATE, 8'h00);
      // Read right behind the event so the checker sees it as well
      @(posedge ref_clk) watchdogRamReset <= 1'b1;
      @(posedge ref_clk) begin
         watchdogRamReset <= 1'b0;
         addr <= LVD_ADDR_RAMSTATE;
         rd <= 1'b1;
      end
      @(posedge ref_clk) rd <= 1'b0;
      #1 chk("ram_invalid_flag", 8'h01, rdata);
      kwr(LVD_ADDR_RAMSTATE, 8'h00);
      wreg(LVD_ADDR_EMU, 8'h01);
      rchk(LVD_ADDR_RAMSTATE, 8'h00);
      rchk(LVD_ADDR_EMU, 8'h00);
      @(posedge ref_clk) emulationMode <= 1'b1;
      wreg(LVD_ADDR_EMU, 8'h01);
      rchk(LVD_ADDR_RAMSTATE, 8'h01);
      rchk(LVD_ADDR_EMU, 8'h01);
      kwr(LVD_ADDR_RAMSTATE, 8'h00);
      rchk(LVD_ADDR_RAMSTATE, 8'h01);
      wreg(LVD_ADDR_EMU, 8'h00);
      kwr(LVD_ADDR_RAMSTATE, 8'h00);
      rchk(LVD_ADDR_RAMSTATE, 8'h00);
      wreg(LVD_ADDR_LEVEL, 8'h01);
      rchk(LVD_ADDR_LEVEL, 8'h01);
      // Brown-out: the system pulls reset while running
      @(posedge ref_clk) rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      rchk(LVD_ADDR_RAMSTATE, LVD_RAM_STATE_REG_RST);
      rchk(LVD_ADDR_CTRL, LVD_CTRL_RST);
      rchk(LVD_ADDR_LEVEL, 8'h00);
      chk("level", 8'h00, 8'(detect_level_select));
      end_of_test();
   end
endmodule : low_voltage_detect_control_bench

//--- testbench/lvd_assertions.sv
`timescale 1ns/1ns
module lvd_assertions import lvd_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic lockRelease,
   input wire logic cmpBelowLevel,
   input wire logic cmpBelowRetention,
   input wire logic watchdogRamReset,
   input wire logic emulationMode,
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic low_volt_irq,
   input wire logic low_volt_reset,
   input wire logic [0:0] detect_level_select
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff rst;
   // Comparator reaches the outputs only after two sampling edges
   a_irq_rst_excl: assert property (!(low_volt_irq && low_volt_reset))
      else $error("irq and reset high together");
   a_irq_cause: assert property (low_volt_irq |-> $past(cmpBelowLevel, 2))
      else $error("irq without synced comparator");
   a_rst_cause: assert property (low_volt_reset |-> $past(cmpBelowLevel, 2))
      else $error("reset without synced comparator");
   a_rst_hold: assert property (low_volt_reset && $past(cmpBelowLevel) && !lockRelease
      |=> low_volt_reset)
      else $error("reset dropped while below level");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside read answer");
   a_ctrl_zero_bits: assert property ($past(rd) && $past(addr) == LVD_ADDR_CTRL
      |-> rdata[6:2] == 5'h00)
      else $error("control unused bits set");
   a_flag_clear: assert property ($past(rd) && $past(addr) == LVD_ADDR_CTRL
      && !$past(cmpBelowLevel, 3) |-> !rdata[0])
      else $error("flag set with supply above level");
   a_ram_invalid_flag_watchdog: assert property ($past(rd) && $past(addr) == LVD_ADDR_RAMSTATE
      && $past(watchdogRamReset, 2) |-> rdata[0])
      else $error("RAM flag not set by watchdog");
   a_level_steady: assert property (!$past(wr) && !$past(lockRelease)
      |-> $stable(detect_level_select))
      else $error("level moved without a write");
endmodule : lvd_assertions
bind low_voltage_detect_control lvd_assertions u_chk (.ref_clk, .rst, .lockRelease,
   .cmpBelowLevel, .cmpBelowRetention, .watchdogRamReset, .emulationMode, .addr, .wdata,
   .wr, .rd, .rdata, .low_volt_irq, .low_volt_reset, .detect_level_select);
